// ### rtl/adc_scan_mapper.sv
/*
 * channel scan mapper: virtual channel register sets, group to unit
 * binding and two scan sequencers behind an AXI4-Lite slave.
 * assumes a single 50 MHz clock and converters on that same clock.
 */
// Contract
// - one register set per virtual channel
// - group limit: 8 sar/ovs, 2-4 hybrid (a hybrid group under 2 still scans and only sets the short flag)
// - ascending order, excess channels dropped
// - unit0 21 se/12 diff, unit1 17/8
// - single-ended vs ground, differential even minus odd
// - pairs are only 2i and 2i+1
// - sign select 1 unsigned, 0 signed
// - extended sources 96-98, 101-104, both units
// - simultaneous starts run lowest group
// - single scan converts each channel once
`timescale 1ns/1ns
module adc_scan_mapper (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [adc_map_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [adc_map_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output wire logic [1:0] conv_valid,
    output wire logic [1:0][adc_map_pkg::CH_W-1:0] conv_channel,
    output wire logic [1:0] conv_diff,
    output wire logic [1:0][adc_map_pkg::VCH_W-1:0] conv_vchan,
    output wire logic [1:0] conv_invalid,
    input wire logic [1:0] conv_ack,
    input wire logic [1:0][adc_map_pkg::RES_W-1:0] conv_result
);
    import adc_map_pkg::*;

    logic [31:0] vch_reg [NUM_VCH];
    logic [31:0] vch_next [NUM_VCH];
    logic [NUM_GROUPS-1:0] gunit_reg, gunit_next, start_reg, start_next;
    logic [3:0] method_reg, method_next, err_reg, err_next;
    logic awready_reg, awready_next, bvalid_reg, bvalid_next;
    logic arready_reg, arready_next, rvalid_reg, rvalid_next;
    logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
    logic [31:0] rdata_reg, rdata_next;
    logic wr_fire, rd_fire;
    logic [NUM_UNITS-1:0] busy, short_evt, inval_evt;
    logic [GRP_W-1:0] agrp [NUM_UNITS];
    logic [RES_W-1:0] result [NUM_UNITS];

    scan_cfg_if cfg [NUM_UNITS] ();

    function automatic logic vch_hit(input logic [ADDR_W-1:0] a);
        vch_hit = a < VCH_BASE + ADDR_W'(4 * NUM_VCH) && a[1:0] == 2'b00;
    endfunction : vch_hit

    function automatic logic [31:0] strobe(input logic [31:0] old,
        input logic [31:0] nw, input logic [3:0] be);
        for (int b = 0; b < 4; b++)
            strobe[8*b +: 8] = be[b] ? nw[8*b +: 8] : old[8*b +: 8];
    endfunction : strobe

    // ***************************************************
    // axi4-lite slave and registers
    // ***************************************************
    assign wr_fire = s_axi_awvalid && s_axi_wvalid && !awready_reg
                     && !bvalid_reg;
    assign rd_fire = s_axi_arvalid && !arready_reg && !rvalid_reg;

    always_comb
    begin
        logic [VCH_W-1:0] wi;
        logic [VCH_W-1:0] ri;
        logic [31:0] st;
        wi = VCH_W'(s_axi_awaddr[ADDR_W-1:2]);
        ri = VCH_W'(s_axi_araddr[ADDR_W-1:2]);
        st = '0;
        vch_next = vch_reg;
        gunit_next = gunit_reg;
        method_next = method_reg;
        start_next = '0;
        err_next = err_reg;
        awready_next = wr_fire;
        bvalid_next = bvalid_reg && !s_axi_bready;
        bresp_next = bresp_reg;
        arready_next = rd_fire;
        rvalid_next = rvalid_reg && !s_axi_rready;
        rresp_next = rresp_reg;
        rdata_next = rdata_reg;
        if (wr_fire)
        begin
            bvalid_next = 1'b1;
            bresp_next = RESP_OKAY;
            if (vch_hit(s_axi_awaddr))
                vch_next[wi] = strobe(vch_reg[wi], s_axi_wdata,
                                      s_axi_wstrb) & VCH_MASK;
            else if (s_axi_awaddr == GROUP_UNIT && s_axi_wstrb[0])
                gunit_next = s_axi_wdata[NUM_GROUPS-1:0];
            else if (s_axi_awaddr == METHOD && s_axi_wstrb[0])
                method_next = s_axi_wdata[3:0];
            else if (s_axi_awaddr == START && s_axi_wstrb[0])
                start_next = s_axi_wdata[NUM_GROUPS-1:0];
            else if (s_axi_awaddr == STATUS && s_axi_wstrb[2])
                err_next = err_reg & ~s_axi_wdata[S_SHORT_LSB +: 4];
            else if (s_axi_awaddr != STATUS)
                bresp_next = RESP_DECERR;
        end
        // events set after the clear, so they win
        err_next = err_next | {inval_evt, short_evt};
        st[S_BUSY_LSB +: 2] = busy;
        st[S_GRP0_LSB +: GRP_W] = agrp[0];
        st[S_GRP1_LSB +: GRP_W] = agrp[1];
        st[S_SHORT_LSB +: 4] = err_reg;
        if (rd_fire)
        begin
            rvalid_next = 1'b1;
            rresp_next = RESP_OKAY;
            rdata_next = '0;
            if (vch_hit(s_axi_araddr))
                rdata_next = vch_reg[ri];
            else if (s_axi_araddr == GROUP_UNIT)
                rdata_next = 32'(gunit_reg);
            else if (s_axi_araddr == METHOD)
                rdata_next = 32'(method_reg);
            else if (s_axi_araddr == STATUS)
                rdata_next = st;
            else if (s_axi_araddr == RESULT0)
                rdata_next = 32'(result[0]);
            else if (s_axi_araddr == RESULT1)
                rdata_next = 32'(result[1]);
            else if (s_axi_araddr != START)
                rresp_next = RESP_DECERR;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            for (int i = 0; i < NUM_VCH; i++)
                vch_reg[i] <= VCH_RESET;
            gunit_reg <= '0;
            method_reg <= '0;
            start_reg <= '0;
            err_reg <= '0;
            awready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rresp_reg <= RESP_OKAY;
            rdata_reg <= '0;
        end
        else
        begin
            vch_reg <= vch_next;
            gunit_reg <= gunit_next;
            method_reg <= method_next;
            start_reg <= start_next;
            err_reg <= err_next;
            awready_reg <= awready_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            arready_reg <= arready_next;
            rvalid_reg <= rvalid_next;
            rresp_reg <= rresp_next;
            rdata_reg <= rdata_next;
        end
    end

    assign s_axi_awready = awready_reg;
    assign s_axi_wready = awready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rdata = rdata_reg;

    // ***************************************************
    // per-unit binding and sequencers
    // ***************************************************
    for (genvar u = 0; u < NUM_UNITS; u++)
    begin : g_unit
        // a vchan holds one group field, so it joins one group only
        always_comb
        begin
            for (int g = 0; g < NUM_GROUPS; g++)
                for (int v = 0; v < NUM_VCH; v++)
                    cfg[u].group_mask[g][v] = vch_reg[v][F_GRP_EN]
                        && vch_reg[v][F_GRP_LSB +: GRP_W] == GRP_W'(g)
                        && gunit_reg[g] == 1'(u);
        end
        for (genvar v = 0; v < NUM_VCH; v++)
        begin : g_vch
            assign cfg[u].vch_channel[v] = vch_reg[v][F_CH_LSB +: CH_W];
            assign cfg[u].vch_diff[v] = vch_reg[v][F_DIFF];
            assign cfg[u].vch_unsigned[v] = vch_reg[v][F_SIGN];
        end
        assign cfg[u].method = method_t'(method_reg[2*u +: 2]);
        assign cfg[u].start = start_reg & (u ? gunit_reg : ~gunit_reg);
        assign busy[u] = cfg[u].busy;
        assign agrp[u] = cfg[u].active_group;
        assign short_evt[u] = cfg[u].short_evt;
        assign inval_evt[u] = cfg[u].invalid_evt;
        assign result[u] = cfg[u].result;

        scan_sequencer #(
            .UNIT(1'(u))
        ) u_seq (
            .aclk(aclk),
            .aresetn(aresetn),
            .cfg(cfg[u]),
            .conv_valid(conv_valid[u]),
            .conv_channel(conv_channel[u]),
            .conv_diff(conv_diff[u]),
            .conv_vchan(conv_vchan[u]),
            .conv_invalid(conv_invalid[u]),
            .conv_ack(conv_ack[u]),
            .conv_result(conv_result[u])
        );
    end
endmodule : adc_scan_mapper

// ### rtl/adc_map_pkg.sv
/*
 * constants, register map, field layout and helpers for the channel scan
 * mapper. assumes a 32-bit AXI4-Lite register bus and two converter units.
 */
package adc_map_pkg;
    // ***************************************************
    // sizes
    // ***************************************************
    localparam int NUM_VCH = 37;
    localparam int NUM_GROUPS = 8;
    localparam int NUM_UNITS = 2;
    localparam int CH_W = 7;
    localparam int GRP_W = 3;
    localparam int VCH_W = 6;
    localparam int CNT_W = 4;
    localparam int RES_W = 16;
    localparam int ADDR_W = 12;

    // ***************************************************
    // register byte offsets
    // ***************************************************
    localparam logic [ADDR_W-1:0] VCH_BASE = 12'h000;
    localparam logic [ADDR_W-1:0] GROUP_UNIT = 12'h100;
    localparam logic [ADDR_W-1:0] METHOD = 12'h104;
    localparam logic [ADDR_W-1:0] START = 12'h108;
    localparam logic [ADDR_W-1:0] STATUS = 12'h10c;
    localparam logic [ADDR_W-1:0] RESULT0 = 12'h110;
    localparam logic [ADDR_W-1:0] RESULT1 = 12'h114;

    // ***************************************************
    // virtual channel control fields
    // ***************************************************
    localparam int F_CH_LSB = 0;
    localparam int F_DIFF = 8;
    localparam int F_SIGN = 9;
    localparam int F_GRP_LSB = 12;
    localparam int F_GRP_EN = 15;
    localparam logic [31:0] VCH_MASK = 32'h0000_f37f;
    localparam logic [31:0] VCH_RESET = 32'h0000_0200;

    // status fields
    localparam int S_BUSY_LSB = 0;
    localparam int S_GRP0_LSB = 4;
    localparam int S_GRP1_LSB = 8;
    localparam int S_SHORT_LSB = 16;
    localparam int S_INVAL_LSB = 18;

    // ***************************************************
    // per-group channel limits and unit channel counts
    // ***************************************************
    localparam logic [CNT_W-1:0] MAX_SAR = 4'h8;
    localparam logic [CNT_W-1:0] MAX_OVS = 4'h8;
    localparam logic [CNT_W-1:0] MAX_HYB = 4'h4;
    localparam logic [CNT_W-1:0] MIN_HYB = 4'h2;
    localparam logic [CH_W-1:0] SE_CH_U0 = 7'h15;
    localparam logic [CH_W-1:0] DIFF_CH_U0 = 7'h0c;
    localparam logic [CH_W-1:0] SE_CH_U1 = 7'h11;
    localparam logic [CH_W-1:0] DIFF_CH_U1 = 7'h08;

    // extended sources
    localparam logic [CH_W-1:0] SRC_SELF_DIAG = 7'h60;
    localparam logic [CH_W-1:0] SRC_TEMP = 7'h61;
    localparam logic [CH_W-1:0] SRC_VREF = 7'h62;
    localparam logic [CH_W-1:0] SRC_DAC_FIRST = 7'h65;
    localparam logic [CH_W-1:0] SRC_DAC_LAST = 7'h68;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic [1:0]
    {
        method_sar = 2'b00,
        method_ovs = 2'b01,
        method_hyb = 2'b10
    } method_t;

    function automatic logic [CNT_W-1:0] method_limit(input method_t m);
        if (m == method_hyb)
            method_limit = MAX_HYB;
        else if (m == method_ovs)
            method_limit = MAX_OVS;
        else
            method_limit = MAX_SAR;
    endfunction : method_limit

    // lowest set bit of a vector, zero when empty
    function automatic logic [VCH_W-1:0] lowest_set(input logic [63:0] v);
        lowest_set = '0;
        for (int i = 63; i >= 0; i--)
        begin
            if (v[i])
                lowest_set = VCH_W'(i);
        end
    endfunction : lowest_set
endpackage : adc_map_pkg

// ### rtl/scan_cfg_if.sv
/*
 * configuration and status carried between the register block and one
 * converter unit's scan sequencer. one instance per unit.
 */
`timescale 1ns/1ns
interface scan_cfg_if;
    import adc_map_pkg::*;
    logic [NUM_VCH-1:0] group_mask [NUM_GROUPS];
    logic [CH_W-1:0] vch_channel [NUM_VCH];
    logic [NUM_VCH-1:0] vch_diff;
    logic [NUM_VCH-1:0] vch_unsigned;
    method_t method;
    logic [NUM_GROUPS-1:0] start;
    logic busy;
    logic [GRP_W-1:0] active_group;
    logic short_evt;
    logic invalid_evt;
    logic [RES_W-1:0] result;

    modport regs (output group_mask, vch_channel, vch_diff, vch_unsigned,
        method, start, input busy, active_group, short_evt, invalid_evt,
        result);
    modport seq (input group_mask, vch_channel, vch_diff, vch_unsigned,
        method, start, output busy, active_group, short_evt, invalid_evt,
        result);
endinterface : scan_cfg_if

// ### rtl/scan_sequencer.sv
/*
 * scan sequencer of one converter unit: picks a started group, walks its
 * virtual channels and hands each conversion to the converter.
 * assumes the converter answers conv_ack on the same clock.
 */
`timescale 1ns/1ns
module scan_sequencer #(
    parameter logic UNIT = 1'b0
) (
    input wire logic aclk,
    input wire logic aresetn,
    scan_cfg_if.seq cfg,
    output logic conv_valid,
    output logic [adc_map_pkg::CH_W-1:0] conv_channel,
    output logic conv_diff,
    output logic [adc_map_pkg::VCH_W-1:0] conv_vchan,
    output logic conv_invalid,
    input wire logic conv_ack,
    input wire logic [adc_map_pkg::RES_W-1:0] conv_result
);
    import adc_map_pkg::*;

    typedef enum logic [1:0]
    {
        st_idle = 2'b00,
        st_run = 2'b01,
        st_wait = 2'b10
    } seq_state_t;

    seq_state_t state_reg, state_next;
    logic [NUM_GROUPS-1:0] pend_reg, pend_next;
    logic [NUM_VCH-1:0] mask_reg, mask_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next, lim_reg, lim_next;
    logic [GRP_W-1:0] grp_reg, grp_next;
    logic valid_reg, valid_next, diff_reg, diff_next, inv_reg, inv_next;
    logic [CH_W-1:0] ch_reg, ch_next;
    logic [VCH_W-1:0] vch_reg, vch_next;
    logic [RES_W-1:0] res_reg, res_next;
    logic short_reg, short_next, ievt_reg, ievt_next;

    // channel can be converted by this unit in the chosen input mode
    function automatic logic usable(input logic [CH_W-1:0] ch,
                                    input logic diff);
        logic [CH_W-1:0] se_n;
        logic [CH_W-1:0] df_n;
        se_n = UNIT ? SE_CH_U1 : SE_CH_U0;
        df_n = UNIT ? DIFF_CH_U1 : DIFF_CH_U0;
        if (ch == SRC_SELF_DIAG)
            usable = diff;
        else if (ch == SRC_TEMP || ch == SRC_VREF
                 || (ch >= SRC_DAC_FIRST && ch <= SRC_DAC_LAST))
            usable = !diff;
        else if (diff)
            usable = !ch[0] && ch < df_n;
        else
            usable = ch < se_n;
    endfunction : usable

    // ***************************************************
    // sequencing
    // ***************************************************
    always_comb
    begin
        logic [GRP_W-1:0] g;
        logic [VCH_W-1:0] v;
        int n;
        g = GRP_W'(lowest_set(64'(pend_reg)));
        v = lowest_set(64'(mask_reg));
        n = 0;
        state_next = state_reg;
        pend_next = pend_reg;
        mask_next = mask_reg;
        cnt_next = cnt_reg;
        lim_next = lim_reg;
        grp_next = grp_reg;
        valid_next = valid_reg;
        diff_next = diff_reg;
        inv_next = inv_reg;
        ch_next = ch_reg;
        vch_next = vch_reg;
        res_next = res_reg;
        short_next = 1'b0;
        ievt_next = 1'b0;
        case (state_reg)
            st_idle:
            begin
                if (|pend_reg)
                begin
                    // lowest group wins a simultaneous start
                    grp_next = g;
                    pend_next[g] = 1'b0;
                    // members frozen for the whole scan
                    mask_next = cfg.group_mask[g];
                    cnt_next = '0;
                    lim_next = method_limit(cfg.method);
                    for (int i = 0; i < NUM_VCH; i++)
                        n += int'(cfg.group_mask[g][i]);
                    short_next = cfg.method == method_hyb
                                 && n < int'(MIN_HYB);
                    state_next = st_run;
                end
            end
            st_run:
            begin
                // channels past the limit are dropped unconverted
                if (mask_reg == '0 || cnt_reg == lim_reg)
                begin
                    mask_next = '0;
                    state_next = st_idle;
                end
                else
                begin
                    // ascending virtual channel order, each once
                    mask_next[v] = 1'b0;
                    cnt_next = cnt_reg + 1'b1;
                    vch_next = v;
                    ch_next = cfg.vch_channel[v];
                    diff_next = cfg.vch_diff[v];
                    inv_next = !usable(cfg.vch_channel[v],
                                       cfg.vch_diff[v]);
                    ievt_next = inv_next;
                    valid_next = 1'b1;
                    state_next = st_wait;
                end
            end
            st_wait:
            begin
                if (conv_ack)
                begin
                    valid_next = 1'b0;
                    // unsigned passes, signed flips offset binary
                    if (cfg.vch_unsigned[vch_reg])
                        res_next = conv_result;
                    else
                        res_next = {~conv_result[RES_W-1],
                                    conv_result[RES_W-2:0]};
                    state_next = st_run;
                end
            end
            default:
                state_next = st_idle;
        endcase
        // a start in the pick cycle is kept
        pend_next = pend_next | cfg.start;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_reg <= st_idle;
            pend_reg <= '0;
            mask_reg <= '0;
            cnt_reg <= '0;
            lim_reg <= MAX_SAR;
            grp_reg <= '0;
            valid_reg <= 1'b0;
            diff_reg <= 1'b0;
            inv_reg <= 1'b0;
            ch_reg <= '0;
            vch_reg <= '0;
            res_reg <= '0;
            short_reg <= 1'b0;
            ievt_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            pend_reg <= pend_next;
            mask_reg <= mask_next;
            cnt_reg <= cnt_next;
            lim_reg <= lim_next;
            grp_reg <= grp_next;
            valid_reg <= valid_next;
            diff_reg <= diff_next;
            inv_reg <= inv_next;
            ch_reg <= ch_next;
            vch_reg <= vch_next;
            res_reg <= res_next;
            short_reg <= short_next;
            ievt_reg <= ievt_next;
        end
    end

    assign conv_valid = valid_reg;
    assign conv_channel = ch_reg;
    assign conv_diff = diff_reg;
    assign conv_vchan = vch_reg;
    assign conv_invalid = inv_reg;
    assign cfg.busy = state_reg != st_idle;
    assign cfg.active_group = grp_reg;
    assign cfg.short_evt = short_reg;
    assign cfg.invalid_evt = ievt_reg;
    assign cfg.result = res_reg;
endmodule : scan_sequencer

// ### tb/adc_scan_mapper_chk.sv
/*
 * port checker for the scan mapper.
 * assumes a bind onto the top module; it sees only that module's ports.
 */
`timescale 1ns/1ns
module adc_scan_mapper_chk (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] conv_valid,
    input wire logic [1:0][adc_map_pkg::CH_W-1:0] conv_channel,
    input wire logic [1:0] conv_diff,
    input wire logic [1:0] conv_invalid,
    input wire logic [1:0] conv_ack
);
    import adc_map_pkg::*;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    b_hold_a: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    r_hold_a: assert property (
        s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    aw_pulse_a: assert property (
        s_axi_awready |-> s_axi_bvalid ##1 !s_axi_awready)
        else $error("write accept not a single pulse");
    conv_hold_a: assert property (
        conv_valid[0] && !conv_ack[0]
        |=> conv_valid[0] && $stable(conv_channel[0]))
        else $error("request changed before ack");
    conv_drop_a: assert property (
        conv_valid[1] && conv_ack[1] |=> !conv_valid[1])
        else $error("request held after ack");
    odd_diff_a: assert property (
        conv_valid[0] && conv_diff[0] && conv_channel[0][0]
        |-> conv_invalid[0])
        else $error("odd differential not flagged");
    se_range_a: assert property (
        conv_valid[0] && !conv_diff[0] && conv_channel[0] < SE_CH_U0
        |-> !conv_invalid[0])
        else $error("usable channel flagged");
    even_diff_a: assert property (
        conv_valid[0] && conv_diff[0] && conv_channel[0] == 7'h04
        |-> !conv_invalid[0])
        else $error("even pair flagged");
endmodule : adc_scan_mapper_chk

bind adc_scan_mapper adc_scan_mapper_chk chk (.*);

// ### tb/test_adc_scan_mapper.sv
/*
 * self-checking bench: bus tasks and a prompt converter stand-in.
 * assumes the package and design are compiled first.
 */
`timescale 1ns/1ns
module test_adc_scan_mapper;
    import adc_map_pkg::*;
    logic aclk = 0;
    logic aresetn = 0;
    logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready;
    logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, conv_valid, conv_diff, conv_invalid;
    logic [1:0] conv_ack = '0;
    logic [1:0][CH_W-1:0] conv_channel;
    logic [1:0][VCH_W-1:0] conv_vchan;
    logic [1:0][RES_W-1:0] conv_result = {2{16'h8001}};
    logic [VCH_W-1:0] seen [2][$];
    logic [VCH_W-1:0] e [$];
    int error_cnt = 0;
    int tests_run = 0;

    adc_scan_mapper dut (.*);
    always #10 aclk = ~aclk;

    // ***************************************************
    // converter stand-in: acks each request one cycle on
    // ***************************************************
    always @(posedge aclk)
        for (int u = 0; u < 2; u++)
        begin
            conv_ack[u] <= conv_valid[u] && !conv_ack[u];
            if (conv_valid[u] && conv_ack[u])
                seen[u].push_back(conv_vchan[u]);
        end

    // ***************************************************
    // bus and compare tasks
    // ***************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do @(posedge aclk); while (!(s_axi_awready && s_axi_wready));
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        // late bready so a held response is seen too
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk(32'(s_axi_bresp), 32'(RESP_OKAY));
    endtask : wr

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] x, m,
        input logic [1:0] rs);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata & m, x);
        chk(32'(s_axi_rresp), 32'(rs));
    endtask : rd

    task automatic vw(input int n, input logic [6:0] c, input logic df, sg,
        input logic [2:0] g);
        wr(VCH_BASE + ADDR_W'(4 * n), {16'h0, 1'b1, g, 2'b0, sg, df, 1'b0, c});
    endtask : vw

    // start groups, then compare the order of converted vchans with e
    task automatic scan(input int u, input logic [7:0] g);
        int n = 0;
        seen[u] = {};
        wr(START, {24'h0, g});
        while (seen[u].size() < e.size() && n++ < 400)
            @(posedge aclk);
        repeat (20) @(posedge aclk);
        chk(32'(seen[u].size()), 32'(e.size()));
        foreach (e[i])
            chk(32'(seen[u][i]), 32'(e[i]));
    endtask : scan

    task automatic wrap_up();
        if (error_cnt == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : wrap_up

    task automatic sar_limit();
        for (int i = 8; i >= 0; i--)
            vw(i, 7'(i), 1'b0, 1'b1, 3'h0);
        e = {0, 1, 2, 3, 4, 5, 6, 7};
        scan(0, 8'h01);
        rd(RESULT0, 32'h8001, 32'hffff, RESP_OKAY);
    endtask : sar_limit

    task automatic hyb_limit();
        wr(GROUP_UNIT, 32'h2);
        wr(METHOD, 32'h8);
        for (int i = 10; i < 15; i++)
            vw(i, 7'(i), 1'b0, 1'b1, 3'h1);
        e = {10, 11, 12, 13};
        scan(1, 8'h02);
    endtask : hyb_limit

    // two groups started together; lowest runs first
    task automatic diff_prio();
        vw(20, 7'h04, 1'b1, 1'b0, 3'h3);
        vw(21, 7'h05, 1'b1, 1'b0, 3'h3);
        e = {0, 1, 2, 3, 4, 5, 6, 7, 20, 21};
        scan(0, 8'h09);
        rd(RESULT0, 32'h0001, 32'hffff, RESP_OKAY);
        rd(STATUS, 32'h40000, 32'h40000, RESP_OKAY);
    endtask : diff_prio

    // extended sources; the temperature source twice in one group
    task automatic ext_src();
        wr(STATUS, 32'h000f_0000);
        vw(30, SRC_TEMP, 1'b0, 1'b1, 3'h2);
        vw(31, SRC_SELF_DIAG, 1'b1, 1'b0, 3'h2);
        vw(32, SRC_TEMP, 1'b0, 1'b1, 3'h2);
        vw(33, SRC_DAC_FIRST, 1'b0, 1'b1, 3'h2);
        e = {30, 31, 32, 33};
        scan(0, 8'h04);
        rd(STATUS, 32'h0000_0120, '1, RESP_OKAY);
    endtask : ext_src

    initial
    begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rd(VCH_BASE + 12'h090, VCH_RESET, '1, RESP_OKAY);
        rd(12'h200, 32'h0, '1, RESP_DECERR);
        sar_limit();
        hyb_limit();
        diff_prio();
        ext_src();
        wrap_up();
    end

    initial
    begin
        repeat (20000) @(posedge aclk);
        error_cnt++;
        wrap_up();
    end
endmodule : test_adc_scan_mapper
